// [core/adcc_map.svh]
// Register offsets, field positions, reset values and cycle counts of the converter control block.
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADCC_OFS_RESULT_LOW   8'h78
`define ADCC_OFS_RESULT_HIGH  8'h79
`define ADCC_OFS_CONTROL_A    8'h7a
`define ADCC_OFS_TRIGGER_B    8'h7b
`define ADCC_OFS_REF_CHANNEL  8'h7c
`define ADCC_OFS_DIG_DISABLE  8'h7e

// ----------------------------------------------------------------------------
// Field positions in converter_control_a
// ----------------------------------------------------------------------------
`define ADCC_CA_ENABLE        7
`define ADCC_CA_START         6
`define ADCC_CA_AUTO          5
`define ADCC_CA_DONE          4
`define ADCC_CA_IE            3

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define ADCC_RST_BYTE         8'h00
`define ADCC_RST_RESULT       10'h000
`define ADCC_TRIG_FREE_RUN    3'h0

// ----------------------------------------------------------------------------
// Conversion lengths in converter clock ticks
// ----------------------------------------------------------------------------
`define ADCC_FIRST_TICKS      5'h19
`define ADCC_NORMAL_TICKS     5'h0d

`endif

// [core/adcc_pkg.sv]
// Types shared by the converter control modules.
package adcc_pkg;

  // Conversion sequencer states.
  typedef enum logic [0:0] {
    st_idle,
    st_conv
  } adcc_state_e;

  // Raw ten-bit conversion code.
  typedef logic [9:0] adcc_result_t;

endpackage : adcc_pkg

// [core/adcc_ctl_if.sv]
// Control signals between the converter top, its prescaler and its trigger detector.
`timescale 1ns/1ps
`default_nettype none

interface adcc_ctl_if;
  logic       enable;
  logic [2:0] div_sel;
  logic       tick;
  logic       auto_en;
  logic [2:0] trig_sel;
  logic       trig_edge;

  modport top   (output enable, output div_sel, output auto_en, output trig_sel,
                 input tick, input trig_edge);
  modport presc (input enable, input div_sel, output tick);
  modport trig  (input auto_en, input trig_sel, output trig_edge);
endinterface : adcc_ctl_if

`default_nettype wire

// [core/adcc_prescaler.sv]
// Converter clock prescaler producing one-cycle tick pulses.
`timescale 1ns/1ps
`default_nettype none

module adcc_prescaler (
  input  wire logic   i_clk,
  input  wire logic   i_rstn,
  adcc_ctl_if.presc   ctl
);

  logic [6:0] div_cnt_q;
  logic [6:0] div_cnt_d;

  // --------------------------------------------------------------------------
  // Division factor decode
  // --------------------------------------------------------------------------
  // Codes 0 and 1 both divide by two; code n otherwise divides by 2**n.
  wire  [2:0] div_shift = (ctl.div_sel == 3'h0) ? 3'h1 : ctl.div_sel;
  wire  [7:0] div_full  = (8'h01 << div_shift) - 8'h01;
  wire  [6:0] div_last  = div_full[6:0];

  // The divider is held at zero while the converter is off, which saves power.
  assign ctl.tick  = ctl.enable && (div_cnt_q == div_last);
  assign div_cnt_d = (!ctl.enable || ctl.tick) ? 7'h00 : div_cnt_q + 7'h01;

  // Divider counter.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn) div_cnt_q <= 7'h00;
    else         div_cnt_q <= div_cnt_d;
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_no_tick_when_off;
    @(posedge i_clk) disable iff (!i_rstn) !ctl.enable |-> !ctl.tick;
  endproperty
  a_no_tick_when_off: assert property (p_no_tick_when_off) else $error("Tick while disabled.");

  property p_div2_spacing;
    @(posedge i_clk) disable iff (!i_rstn)
      (ctl.tick && ctl.div_sel == 3'h1 && ctl.enable) ##1 (ctl.enable && $stable(ctl.div_sel)) |->
        !ctl.tick ##1 (ctl.tick || !ctl.enable || $changed(ctl.div_sel));
  endproperty
  a_div2_spacing: assert property (p_div2_spacing) else $error("Divide by two not kept.");

endmodule : adcc_prescaler

`default_nettype wire

// [core/adcc_trigger.sv]
// Auto-trigger source selection and rising edge detection.
`timescale 1ns/1ps
`default_nettype none

module adcc_trigger (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic [7:1] i_trig_flags,
  adcc_ctl_if.trig        ctl
);

  logic sel_level_q;

  // --------------------------------------------------------------------------
  // Source selection
  // --------------------------------------------------------------------------
  // Code 0 selects a constant low level, so entering free running makes no edge.
  wire sel_level = (ctl.trig_sel == 3'h0) ? 1'b0 : i_trig_flags[ctl.trig_sel];
  // The previous level follows whatever source is selected, so a switch onto a
  // set flag is seen as a rising edge.
  assign ctl.trig_edge = ctl.auto_en && sel_level && !sel_level_q;

  // Previous selected level.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn) sel_level_q <= 1'b0;
    else         sel_level_q <= sel_level;
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_no_edge_without_auto;
    @(posedge i_clk) disable iff (!i_rstn) !ctl.auto_en |-> !ctl.trig_edge;
  endproperty
  a_no_edge_without_auto: assert property (p_no_edge_without_auto) else $error("Edge with auto off.");

  property p_free_run_no_edge;
    @(posedge i_clk) disable iff (!i_rstn) (ctl.trig_sel == 3'h0) |-> !ctl.trig_edge;
  endproperty
  a_free_run_no_edge: assert property (p_free_run_no_edge) else $error("Edge in free running.");

endmodule : adcc_trigger

`default_nettype wire

// [core/adcc_top.sv]
// Converter control top: registers, conversion sequencer, result lock and pin buffer control.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.svh"

module adcc_top (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic [9:0] i_analog_code,
  input  wire logic [7:1] i_trig_flags,
  input  wire logic       i_global_ie,
  input  wire logic       i_irq_ack,
  input  wire logic [5:0] i_port_pin,
  output logic      [5:0] o_port_pin,
  output logic      [5:0] o_buffer_off,
  output logic            o_power_on,
  output logic      [1:0] o_ref_sel,
  output logic      [3:0] o_chan_sel,
  output logic            o_conv_tick,
  output logic            o_busy,
  output logic            o_irq
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  adcc_pkg::adcc_state_e  state_q;
  adcc_pkg::adcc_state_e  state_d;
  adcc_pkg::adcc_result_t result_q;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       en_q;
  logic       auto_q;
  logic       flag_q;
  logic       ie_q;
  logic [2:0] div_q;
  logic [2:0] trig_q;
  logic [1:0] ref_q;
  logic       left_q;
  logic [3:0] mux_q;
  logic [1:0] act_ref_q;
  logic [3:0] act_mux_q;
  logic [5:0] didr_q;
  logic [5:0] port_q;
  logic       lock_q;
  logic       first_q;
  logic [7:0] rdata_q;

  adcc_ctl_if ctl ();

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  wire wr_ctrl = i_wr && (i_addr == `ADCC_OFS_CONTROL_A);
  wire wr_trig = i_wr && (i_addr == `ADCC_OFS_TRIGGER_B);
  wire wr_mux  = i_wr && (i_addr == `ADCC_OFS_REF_CHANNEL);
  wire wr_didr = i_wr && (i_addr == `ADCC_OFS_DIG_DISABLE);
  wire rd_low  = i_rd && (i_addr == `ADCC_OFS_RESULT_LOW);
  wire rd_high = i_rd && (i_addr == `ADCC_OFS_RESULT_HIGH);

  // --------------------------------------------------------------------------
  // Sequencer decode
  // --------------------------------------------------------------------------
  wire idle      = (state_q == adcc_pkg::st_idle);
  wire busy      = (state_q == adcc_pkg::st_conv);
  // A start with the enable bit written low in the same byte is dropped, and a
  // written zero in the start position does nothing.
  wire sw_start  = wr_ctrl && i_wdata[`ADCC_CA_START] && i_wdata[`ADCC_CA_ENABLE];
  wire hw_start  = ctl.trig_edge && en_q;
  wire start     = idle && (sw_start || hw_start);
  wire abort     = busy && wr_ctrl && !i_wdata[`ADCC_CA_ENABLE];
  wire [4:0] len_last = first_q ? (`ADCC_FIRST_TICKS - 5'h01)
                                : (`ADCC_NORMAL_TICKS - 5'h01);
  wire done_evt  = busy && !abort && ctl.tick && (cnt_q == len_last);
  wire free_run  = auto_q && (trig_q == `ADCC_TRIG_FREE_RUN);
  wire restart   = done_evt && free_run;
  wire flag_clr  = (wr_ctrl && i_wdata[`ADCC_CA_DONE]) || i_irq_ack;

  // Next state: free running keeps converting until the enable or auto bit is cleared or a source other than 0 is chosen.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      adcc_pkg::st_idle: if (start) state_d = adcc_pkg::st_conv;
      adcc_pkg::st_conv: if (abort || (done_evt && !restart)) state_d = adcc_pkg::st_idle;
      default:           state_d = adcc_pkg::st_idle;
    endcase
  end

  // The tick counter restarts at every new conversion and at an abort.
  assign cnt_d = (start || restart || abort) ? 5'h00 :
                 (busy && ctl.tick)          ? cnt_q + 5'h01 : cnt_q;

  // --------------------------------------------------------------------------
  // Submodule wiring
  // --------------------------------------------------------------------------
  assign ctl.enable   = en_q;
  assign ctl.div_sel  = div_q;
  assign ctl.auto_en  = auto_q;
  assign ctl.trig_sel = trig_q;

  adcc_prescaler u_prescaler (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .ctl    (ctl.presc)
  );

  adcc_trigger u_trigger (
    .i_clk        (i_clk),
    .i_rstn       (i_rstn),
    .i_trig_flags (i_trig_flags),
    .ctl          (ctl.trig)
  );

  // --------------------------------------------------------------------------
  // Sequencer registers
  // --------------------------------------------------------------------------
  // While off, the first-conversion marker is re-armed so the next start runs the long one.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state_q <= adcc_pkg::st_idle;
      cnt_q   <= 5'h00;
      first_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      first_q <= !en_q || (first_q && !done_evt);
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  // Reserved bits of the trigger and disable registers are not stored.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      en_q   <= 1'b0;
      auto_q <= 1'b0;
      ie_q   <= 1'b0;
      div_q  <= 3'h0;
      trig_q <= 3'h0;
      ref_q  <= 2'h0;
      left_q <= 1'b0;
      mux_q  <= 4'h0;
      didr_q <= 6'h00;
    end
    else
    begin
      if (wr_ctrl)
      begin
        en_q   <= i_wdata[`ADCC_CA_ENABLE];
        auto_q <= i_wdata[`ADCC_CA_AUTO];
        ie_q   <= i_wdata[`ADCC_CA_IE];
        div_q  <= i_wdata[2:0];
      end
      if (wr_trig) trig_q <= i_wdata[2:0];
      if (wr_mux)
      begin
        ref_q  <= i_wdata[7:6];
        left_q <= i_wdata[5];
        mux_q  <= i_wdata[3:0];
      end
      if (wr_didr) didr_q <= i_wdata[5:0];
    end
  end

  // Done flag: a completion in the same cycle as a clear leaves it set.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn) flag_q <= 1'b0;
    else         flag_q <= done_evt || (flag_q && !flag_clr);
  end

  // --------------------------------------------------------------------------
  // Active selection and result
  // --------------------------------------------------------------------------
  // The analog side sees a held copy so a write mid-conversion cannot disturb
  // the sample; the copy follows software while idle and at each completion.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      act_ref_q <= 2'h0;
      act_mux_q <= 4'h0;
    end
    else if (idle || done_evt)
    begin
      act_ref_q <= ref_q;
      act_mux_q <= mux_q;
    end
  end

  // A held lock drops the new code; the flag still reports the completion.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)                    result_q <= `ADCC_RST_RESULT;
    else if (done_evt && !lock_q)   result_q <= i_analog_code;
  end

  // Lock is taken by a low byte read and released by a high byte read.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)      lock_q <= 1'b0;
    else if (rd_low)  lock_q <= 1'b1;
    else if (rd_high) lock_q <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Alignment is applied at read time, so a change shows at once.
  wire [7:0] low_byte  = left_q ? {result_q[1:0], 6'h00} : result_q[7:0];
  wire [7:0] high_byte = left_q ? result_q[9:2] : {6'h00, result_q[9:8]};
  wire [7:0] ctrl_byte = {en_q, busy, auto_q, flag_q, ie_q, div_q};
  wire [7:0] mux_byte  = {ref_q, left_q, 1'b0, mux_q};
  wire [7:0] rd_val    = (i_addr == `ADCC_OFS_RESULT_LOW)  ? low_byte  :
                         (i_addr == `ADCC_OFS_RESULT_HIGH) ? high_byte :
                         (i_addr == `ADCC_OFS_CONTROL_A)   ? ctrl_byte :
                         (i_addr == `ADCC_OFS_TRIGGER_B)   ? {5'h00, trig_q} :
                         (i_addr == `ADCC_OFS_REF_CHANNEL) ? mux_byte  :
                         (i_addr == `ADCC_OFS_DIG_DISABLE) ? {2'h0, didr_q} : `ADCC_RST_BYTE;

  // Read data stand for one cycle only; unmapped addresses read zero.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn) rdata_q <= `ADCC_RST_BYTE;
    else         rdata_q <= i_rd ? rd_val : `ADCC_RST_BYTE;
  end

  // Port input with disabled buffers forced low.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn) port_q <= 6'h00;
    else         port_q <= i_port_pin & ~didr_q;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_rdata      = rdata_q;
  assign o_port_pin   = port_q;
  assign o_buffer_off = didr_q;
  assign o_power_on   = en_q;
  assign o_ref_sel    = act_ref_q;
  assign o_chan_sel   = act_mux_q;
  assign o_conv_tick  = busy && ctl.tick;
  assign o_busy       = busy;
  assign o_irq        = flag_q && ie_q && i_global_ie;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_flag_on_done;
    done_evt |=> flag_q && (lock_q || $past(lock_q) || result_q == $past(i_analog_code));
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) else $error("Completion not recorded.");

  property p_flag_clear;
    (wr_ctrl && i_wdata[`ADCC_CA_DONE] && !done_evt) |=> !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Flag not cleared by one.");

  property p_irq_cause;
    o_irq |-> flag_q && ie_q && i_global_ie;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("Spurious interrupt.");

  property p_abort;
    (busy && wr_ctrl && !i_wdata[`ADCC_CA_ENABLE]) |=> !o_busy && !flag_q [*1] or (!o_busy && $past(flag_q));
  endproperty
  a_abort: assert property (p_abort) else $error("Conversion not aborted.");

  property p_busy_readback;
    (i_rd && i_addr == `ADCC_OFS_CONTROL_A) |=> o_rdata[`ADCC_CA_START] == $past(busy);
  endproperty
  a_busy_readback: assert property (p_busy_readback) else $error("Start bit mismatch.");

  property p_lock_holds;
    (done_evt && lock_q) |=> $stable(result_q);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("Locked result changed.");

  property p_sel_held;
    (busy && !done_evt) |=> $stable(o_chan_sel) && $stable(o_ref_sel);
  endproperty
  a_sel_held: assert property (p_sel_held) else $error("Selection changed mid-conversion.");

  property p_reserved_zero;
    (i_rd && i_addr == `ADCC_OFS_REF_CHANNEL) |=> o_rdata[4] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set.");

  property p_right_high;
    (i_rd && i_addr == `ADCC_OFS_RESULT_HIGH && !left_q) |=> o_rdata == {6'h00, $past(result_q[9:8])};
  endproperty
  a_right_high: assert property (p_right_high) else $error("High byte layout wrong.");

  property p_length;
    done_evt |-> cnt_q == (first_q ? 5'h18 : 5'h0c);
  endproperty
  a_length: assert property (p_length) else $error("Conversion length wrong.");

  c_first_done: cover property (start ##[1:200] done_evt);
  c_free_run:   cover property (restart);
  c_lock_drop:  cover property (done_evt && lock_q);

endmodule : adcc_top

`default_nettype wire

// [dv/adcc_analog_model.sv]
// Behavioural model of the analog converter core that feeds codes to the control block.
`timescale 1ns/1ps
`default_nettype none

module adcc_analog_model (
  input  wire logic       i_power_on,
  input  wire logic [1:0] i_ref_sel,
  input  wire logic [3:0] i_chan_sel,
  output logic      [9:0] o_code
);
  // --------------------------------------------------------------------------
  // Code generation
  // --------------------------------------------------------------------------
  // Ground gives the lowest code; other routes give a code built from reference and channel, so a mixup shows.
  // A powered-down core gives the inverted code, so a result taken while off cannot pass for a good one.
  logic [9:0] route_code;
  assign route_code = (i_chan_sel == 4'hf) ? 10'h000 : {i_ref_sel, i_chan_sel, 4'ha};
  assign o_code     = i_power_on ? route_code : ~route_code;
endmodule : adcc_analog_model

`default_nettype wire

// [dv/adc_conversion_control_bench.sv]
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_control_bench;
  logic       i_clk = 1'b0;
  logic       i_rstn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:1] i_trig_flags = 7'h00;
  logic       i_global_ie = 1'b0;
  logic       i_irq_ack = 1'b0;
  logic [5:0] i_port_pin = 6'h00;
  logic [7:0] o_rdata;
  logic [9:0] code;
  logic [5:0] o_port_pin, o_buffer_off;
  logic [1:0] o_ref_sel;
  logic [3:0] o_chan_sel;
  logic       o_power_on, o_conv_tick, o_busy, o_irq;
  int         fail_count = 0;
  int         cmp_count = 0;

  // The clock runs at 50 MHz.
  always #10 i_clk = ~i_clk;

  adcc_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_analog_code(code), .i_trig_flags(i_trig_flags), .i_global_ie(i_global_ie),
    .i_irq_ack(i_irq_ack), .i_port_pin(i_port_pin), .o_port_pin(o_port_pin), .o_buffer_off(o_buffer_off),
    .o_power_on(o_power_on), .o_ref_sel(o_ref_sel), .o_chan_sel(o_chan_sel), .o_conv_tick(o_conv_tick),
    .o_busy(o_busy), .o_irq(o_irq));

  adcc_analog_model core (.i_power_on(o_power_on), .i_ref_sel(o_ref_sel), .i_chan_sel(o_chan_sel), .o_code(code));

  // --------------------------------------------------------------------------
  // Access and checking tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the read edge, so they are sampled at that cycle's falling edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, e);
  endtask : rd

  // Counts converter ticks and their spacing until busy drops; n of zero only checks that busy rose, then waits.
  task automatic conv(input int n, input int d);
    int t, k, last, gap;
    t = 0; k = 0; last = 0; gap = 0;
    // The first busy cycle is looked at too, since a tick may already fall in it.
    do
    begin
      @(negedge i_clk);
      t++;
    end
    while (o_busy !== 1'b1 && t < 100);
    chk(o_busy, 1'b1);
    t = 0;
    while (o_busy === 1'b1 && t < 4000)
    begin
      if (o_conv_tick === 1'b1)
      begin
        if (k > 0) gap = t - last;
        last = t;
        k++;
      end
      @(negedge i_clk);
      t++;
    end
    if (n > 0)
    begin
      chk(k, n);
      chk(gap, d);
    end
  endtask : conv

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // A hang is cut short well beyond the expected run length.
  initial
  begin
    #(20 * 30000);
    fail_count++;
    wrap_up();
  end

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(8'h78, 8'h00); rd(8'h79, 8'h00); rd(8'h7a, 8'h00); rd(8'h7c, 8'h00); rd(8'h7e, 8'h00);
    rd(8'h7b, 8'h00); rd(8'h7d, 8'h00);
    wr(8'h7c, 8'h53);
    rd(8'h7c, 8'h43);
    chk({o_ref_sel, o_chan_sel}, 6'h13);
    @(posedge i_clk);
    i_port_pin <= 6'h2d;
    wr(8'h7e, 8'hff);
    rd(8'h7e, 8'h3f);
    chk({o_buffer_off, o_port_pin}, 12'hfc0);
    wr(8'h7e, 8'h05);
    // The pin register follows the disable bits one edge later.
    repeat (2) @(negedge i_clk);
    chk(o_port_pin, 6'h28);
    $display("test registers done");
    @(posedge i_clk);
    i_global_ie <= 1'b1;
    wr(8'h7a, 8'hc8);
    wr(8'h7c, 8'hc5);
    @(negedge i_clk);
    chk({o_ref_sel, o_chan_sel}, 6'h13);
    rd(8'h7a, 8'hc8);
    conv(0, 0);
    chk({o_ref_sel, o_chan_sel}, 6'h35);
    chk(o_irq, 1'b1);
    rd(8'h7a, 8'h98);
    rd(8'h78, 8'h3a);
    @(posedge i_clk);
    i_irq_ack <= 1'b1;
    @(posedge i_clk);
    i_irq_ack <= 1'b0;
    @(negedge i_clk);
    chk(o_irq, 1'b0);
    wr(8'h7a, 8'hc0);
    conv(13, 2);
    chk(o_irq, 1'b0);
    rd(8'h79, 8'h01);
    rd(8'h78, 8'h3a);
    rd(8'h79, 8'h01);
    wr(8'h7c, 8'he5);
    rd(8'h79, 8'h4e);
    wr(8'h7a, 8'hc0);
    conv(0, 0);
    rd(8'h78, 8'h80);
    rd(8'h79, 8'hd6);
    wr(8'h7a, 8'h90);
    wr(8'h7a, 8'h80);
    rd(8'h7a, 8'h80);
    $display("test conversion done");
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h7a, 8'hc0 | 8'(c));
      conv(13, (c < 2) ? 2 : (1 << c));
    end
    $display("test prescaler done");
    wr(8'h7a, 8'h90);
    wr(8'h7a, 8'hc0);
    wr(8'h7a, 8'h00);
    rd(8'h7a, 8'h00);
    chk({o_busy, o_power_on}, 2'b00);
    wr(8'h7a, 8'hc0);
    conv(25, 2);
    wr(8'h7b, 8'h01);
    i_trig_flags <= 7'h7f;
    repeat (10) @(posedge i_clk);
    chk(o_busy, 1'b0);
    i_trig_flags <= 7'h00;
    wr(8'h7a, 8'ha0);
    for (int s = 1; s < 8; s++)
    begin
      wr(8'h7b, 8'(s));
      i_trig_flags[s] <= 1'b1;
      conv(13, 2);
      @(posedge i_clk);
      i_trig_flags <= 7'h00;
    end
    wr(8'h7b, 8'h02);
    i_trig_flags <= 7'h01;
    wr(8'h7b, 8'h01);
    conv(13, 2);
    // All sources low while the done flag is set, so a done-flag edge would show.
    @(posedge i_clk);
    i_trig_flags <= 7'h00;
    wr(8'h7b, 8'h00);
    repeat (10) @(posedge i_clk);
    chk(o_busy, 1'b0);
    wr(8'h7a, 8'hf0);
    repeat (80) @(posedge i_clk);
    rd(8'h7a, 8'hf0);
    wr(8'h7a, 8'h00);
    $display("test trigger done");
    wrap_up();
  end
endmodule : adc_conversion_control_bench

`default_nettype wire
